// ---- inc/phy_side_consts.vh ----
// Constants for the physical-layer side controller of the bit link
`ifndef PHY_SIDE_CONSTS_VH
`define PHY_SIDE_CONSTS_VH

// Clock and channel bit rate
`define SYS_CLK_HZ 20000000
`define BIT_RATE_HZ 10000000
`define BIT_DIV (`SYS_CLK_HZ / `BIT_RATE_HZ)

// Channel and frame figures, in bit times and octets
`define ROUND_TRIP_BITS 16'h01c2
`define OCTET_BITS 8
`define ADDR_OCTETS 6
`define MIN_FRAME_BITS 16'h0200
`define MAX_FRAME_BITS 16'h2f70

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TX_DATA 8'h08
`define REG_RX_DATA 8'h0c
`define REG_STRETCH 8'h10
`define REG_COLL_DELAY 8'h14
`define REG_TX_COUNT 8'h18

// Control fields
`define CTRL_COLLIDE 0
`define CTRL_CARRIER 1

// Reset values
`define STRETCH_RESET 16'h0040
`define COLL_DELAY_RESET 16'h0000

// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- logic/bit_timer.v ----
// Bit-time tick generator and bit-time wait service
module bit_timer #(
   parameter DIV = 2,
   parameter CW = 16
)(
   input wire sys_clk,
   input wire rst_n,
   output reg bit_tick,
   input wire wait_start,
   input wire [CW-1:0] wait_bits,
   output reg wait_done,
   output reg wait_busy
);
   reg [15:0] div_cnt;
   reg [CW-1:0] wait_left;

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         div_cnt <= 16'h0000;
         bit_tick <= 1'b0;
         wait_left <= {CW{1'b0}};
         wait_done <= 1'b0;
         wait_busy <= 1'b0;
      end
      else
      begin
         bit_tick <= (div_cnt == DIV[15:0] - 16'h0001);
         if (div_cnt == DIV[15:0] - 16'h0001)
            div_cnt <= 16'h0000;
         else
            div_cnt <= div_cnt + 16'h0001;
         wait_done <= 1'b0;
         // Counts bit ticks requested by the link side; the first tick can come part way into a bit time
         if (wait_start && !wait_busy)
         begin
            if (wait_bits == {CW{1'b0}})
               wait_done <= 1'b1;
            else
            begin
               wait_left <= wait_bits;
               wait_busy <= 1'b1;
            end
         end
         else if (wait_busy && bit_tick)
         begin
            wait_left <= wait_left - {{(CW-1){1'b0}}, 1'b1};
            if (wait_left == {{(CW-1){1'b0}}, 1'b1})
            begin
               wait_busy <= 1'b0;
               wait_done <= 1'b1;
            end
         end
      end
   end
endmodule

// ---- logic/rx_octet_feed.v ----
// One-octet holder that hands its bits out low bit first
module rx_octet_feed #(
   parameter W = 8
)(
   input wire sys_clk,
   input wire rst_n,
   input wire load,
   input wire [W-1:0] load_data,
   input wire take,
   output reg full,
   output wire bit_out
);
   reg [W-1:0] shift;
   reg [7:0] left;

   // Low bit leaves first, matching the line order within an octet
   assign bit_out = shift[0];

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         shift <= {W{1'b0}};
         left <= 8'h00;
         full <= 1'b0;
      end
      else if (load && !full)
      begin
         shift <= load_data;
         left <= W[7:0];
         full <= 1'b1;
      end
      else if (take && full)
      begin
         shift <= {1'b0, shift[W-1:1]};
         left <= left - 8'h01;
         if (left == 8'h01)
            full <= 1'b0;
      end
   end
endmodule

// ---- logic/phy_link_host.v ----
// Physical-layer side controller driving the data link bit interface
//
// Overview of operation
// - One bit per transfer, next accepted at a later bit tick
// - First transmit transfer stretched for preamble work
// - Collision held asserted while collision persists
// - Collision only while this station transmits
// - Receive transfers deliver stripped bits, first longer
// - Carrier may lead and lag frame bits
// - Transfer pending at carrier fall returns undefined
// - Wait service counts whole channel bit times; here it counts bit ticks, so the first can be part of a bit time
// - Round trip bounded by 450 bit times
// - Frame bounds come only from indications
// - Five fields, only data variable in size
// - Octets low bit first, fields in order
// - Address fields are six octets
// - Valid frames span 64 to 1518 octets
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`include "phy_side_consts.vh"

module phy_link_host #(
   parameter BIT_DIV = `BIT_DIV,
   parameter CW = 16
)(
   input wire sys_clk,
   input wire rst_n,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire tx_active,
   input wire tx_bit_transfer_valid,
   input wire tx_bit_transfer_data,
   output reg tx_bit_transfer_ready,
   output reg collision_flag,
   output reg carrier_present,
   input wire rx_bit_fetch_ready,
   output reg rx_bit_fetch_valid,
   output reg rx_bit_fetch_data,
   output reg rx_bit_undefined,
   input wire wait_req,
   input wire [CW-1:0] wait_bits,
   output wire wait_done
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   reg ctrl_collide;
   reg ctrl_carrier;
   reg [15:0] stretch;
   reg [15:0] coll_delay;
   reg [7:0] aw_addr;
   reg aw_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_held;
   reg tx_was_active;
   reg tx_first;
   reg [15:0] tx_stretch_left;
   reg [15:0] tx_time;
   reg [15:0] tx_bits;
   reg [7:0] tx_shift;
   reg [7:0] tx_octet;
   reg tx_octet_ready;
   reg frame_done;
   reg frame_short;
   reg frame_long;
   reg frame_misaligned;
   reg dest_multicast;
   reg rx_first;
   reg [15:0] rx_stretch_left;
   wire bit_tick;
   wire wait_busy;
   wire feed_full;
   wire feed_bit;
   wire tx_take;
   wire tx_bit_due;
   wire rx_bit_due;
   wire rx_take;
   wire wr_fire;
   wire rd_fire;
   wire [15:0] coll_limit;
   reg [31:0] rd_mux;

   // Decodes a byte offset into a register select, 7 when unmapped
   function [2:0] reg_sel;
      input [7:0] addr;
      begin
         case (addr)
            `REG_CTRL: reg_sel = 3'h0;
            `REG_STATUS: reg_sel = 3'h1;
            `REG_TX_DATA: reg_sel = 3'h2;
            `REG_RX_DATA: reg_sel = 3'h3;
            `REG_STRETCH: reg_sel = 3'h4;
            `REG_COLL_DELAY: reg_sel = 3'h5;
            `REG_TX_COUNT: reg_sel = 3'h6;
            default: reg_sel = 3'h7;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bit clock, wait service and receive octet holder
   bit_timer #(
      .DIV(BIT_DIV),
      .CW(CW)
   ) u_bit_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .bit_tick(bit_tick),
      .wait_start(wait_req),
      .wait_bits(wait_bits),
      .wait_done(wait_done),
      .wait_busy(wait_busy)
   );

   rx_octet_feed #(
      .W(`OCTET_BITS)
   ) u_rx_feed (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(wr_fire && reg_sel(aw_addr) == 3'h3 && w_strb[0]),
      .load_data(w_data[7:0]),
      .take(rx_take),
      .full(feed_full),
      .bit_out(feed_bit)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register bus slave
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         ctrl_collide <= 1'b0;
         ctrl_carrier <= 1'b0;
         stretch <= `STRETCH_RESET;
         coll_delay <= `COLL_DELAY_RESET;
      end
      else
      begin
         // Address and data are taken in either order, one write at a time
         s_axi_awready <= s_axi_awvalid && !aw_held && !s_axi_awready;
         s_axi_wready <= s_axi_wvalid && !w_held && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_fire)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            case (reg_sel(aw_addr))
               3'h0:
               begin
                  if (w_strb[0])
                  begin
                     ctrl_collide <= w_data[`CTRL_COLLIDE];
                     ctrl_carrier <= w_data[`CTRL_CARRIER];
                  end
               end
               3'h4:
               begin
                  if (w_strb[0])
                     stretch[7:0] <= w_data[7:0];
                  if (w_strb[1])
                     stretch[15:8] <= w_data[15:8];
               end
               3'h5:
               begin
                  if (w_strb[0])
                     coll_delay[7:0] <= w_data[7:0];
                  if (w_strb[1])
                     coll_delay[15:8] <= w_data[15:8];
               end
               3'h7: s_axi_bresp <= `RESP_SLVERR;
               default: s_axi_bresp <= `RESP_OKAY;
            endcase
         end
      end
   end

   always @*
   begin
      case (reg_sel(s_axi_araddr))
         3'h0: rd_mux = {30'h00000000, ctrl_carrier, ctrl_collide};
         3'h1: rd_mux = {21'h000000, wait_busy, dest_multicast,
            frame_misaligned, frame_long, frame_short, frame_done,
            tx_octet_ready, feed_full, carrier_present, collision_flag,
            tx_active};
         3'h2: rd_mux = {24'h000000, tx_octet};
         3'h3: rd_mux = {31'h00000000, feed_full};
         3'h4: rd_mux = {16'h0000, stretch};
         3'h5: rd_mux = {16'h0000, coll_delay};
         3'h6: rd_mux = {16'h0000, tx_bits};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
         if (rd_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            if (reg_sel(s_axi_araddr) == 3'h7)
               s_axi_rresp <= `RESP_SLVERR;
            else
               s_axi_rresp <= `RESP_OKAY;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit bit acceptance and frame capture
   // First transfer is held off for the preamble stretch
   // No bit at the rise edge itself, so the stretch is never skipped
   assign tx_bit_due = bit_tick && tx_was_active &&
      (!tx_first || tx_stretch_left == 16'h0000);
   assign tx_take = tx_bit_transfer_valid && tx_bit_transfer_ready;
   // Collision distance never exceeds the channel round trip
   assign coll_limit = (coll_delay > `ROUND_TRIP_BITS) ?
      `ROUND_TRIP_BITS : coll_delay;

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         tx_was_active <= 1'b0;
         tx_first <= 1'b0;
         tx_stretch_left <= 16'h0000;
         tx_time <= 16'h0000;
         tx_bits <= 16'h0000;
         tx_shift <= 8'h00;
         tx_octet <= 8'h00;
         tx_octet_ready <= 1'b0;
         tx_bit_transfer_ready <= 1'b0;
         collision_flag <= 1'b0;
         frame_done <= 1'b0;
         frame_short <= 1'b0;
         frame_long <= 1'b0;
         frame_misaligned <= 1'b0;
         dest_multicast <= 1'b0;
      end
      else
      begin
         tx_was_active <= tx_active;
         // One bit per handshake, paced by the channel bit rate
         tx_bit_transfer_ready <= tx_active && tx_bit_transfer_valid &&
            !tx_bit_transfer_ready && tx_bit_due;
         // Raised only while transmitting, held while the request stands
         collision_flag <= tx_active && ctrl_collide &&
            tx_time >= coll_limit;
         if (tx_active && !tx_was_active)
         begin
            // Frame start comes from transmit-active alone
            tx_first <= 1'b1;
            tx_stretch_left <= stretch;
            tx_time <= 16'h0000;
            tx_bits <= 16'h0000;
         end
         else if (tx_active && bit_tick)
         begin
            if (tx_time != 16'hffff)
               tx_time <= tx_time + 16'h0001;
            if (tx_first && tx_stretch_left != 16'h0000)
               tx_stretch_left <= tx_stretch_left - 16'h0001;
         end
         if (tx_take)
         begin
            tx_first <= 1'b0;
            // Bits arrive low bit first within each octet
            tx_shift <= {tx_bit_transfer_data, tx_shift[7:1]};
            if (tx_bits != 16'hffff)
               tx_bits <= tx_bits + 16'h0001;
            // First bit of the destination marks multicast
            if (tx_bits == 16'h0000)
               dest_multicast <= tx_bit_transfer_data;
         end
         // Read of the octet register clears its flag; a new octet wins
         if (rd_fire && reg_sel(s_axi_araddr) == 3'h2)
            tx_octet_ready <= 1'b0;
         if (tx_take && tx_bits[2:0] == 3'h7)
         begin
            tx_octet <= {tx_bit_transfer_data, tx_shift[7:1]};
            tx_octet_ready <= 1'b1;
         end
         // Frame end and size checks on transmit-active fall
         if (rd_fire && reg_sel(s_axi_araddr) == 3'h1)
            frame_done <= 1'b0;
         if (!tx_active && tx_was_active)
         begin
            frame_done <= 1'b1;
            frame_short <= tx_bits < `MIN_FRAME_BITS;
            frame_long <= tx_bits > `MAX_FRAME_BITS;
            frame_misaligned <= tx_bits[2:0] != 3'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive bit delivery
   // Frame bits only flow while an octet is loaded; carrier may lead it
   assign rx_bit_due = bit_tick && (!rx_first || rx_stretch_left == 16'h0000);
   assign rx_take = carrier_present && ctrl_carrier && rx_bit_fetch_ready &&
      !rx_bit_fetch_valid && feed_full && rx_bit_due;

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         carrier_present <= 1'b0;
         rx_first <= 1'b0;
         rx_stretch_left <= 16'h0000;
         rx_bit_fetch_valid <= 1'b0;
         rx_bit_fetch_data <= 1'b0;
         rx_bit_undefined <= 1'b0;
      end
      else
      begin
         carrier_present <= ctrl_carrier;
         rx_bit_fetch_valid <= 1'b0;
         rx_bit_undefined <= 1'b0;
         if (ctrl_carrier && !carrier_present)
         begin
            rx_first <= 1'b1;
            rx_stretch_left <= stretch;
         end
         else if (rx_first && bit_tick && rx_stretch_left != 16'h0000)
            rx_stretch_left <= rx_stretch_left - 16'h0001;
         if (rx_take)
         begin
            // Preamble already gone; first bit comes after the stretch
            rx_first <= 1'b0;
            rx_bit_fetch_valid <= 1'b1;
            rx_bit_fetch_data <= feed_bit;
         end
         else if (carrier_present && !ctrl_carrier && rx_bit_fetch_ready &&
            !rx_bit_fetch_valid)
         begin
            // A pending fetch at carrier fall gets a marked junk bit
            rx_bit_fetch_valid <= 1'b1;
            rx_bit_fetch_data <= 1'b0;
            rx_bit_undefined <= 1'b1;
         end
      end
   end
endmodule

// ---- tb/phy_link_host_chk.sv ----
// Assertion checker for the bit link ports of the controller
module phy_link_host_chk (
   input wire sys_clk,
   input wire rst_n,
   input wire s_axi_awvalid,
   input wire tx_active,
   input wire tx_bit_transfer_valid,
   input wire tx_bit_transfer_ready,
   input wire collision_flag,
   input wire carrier_present,
   input wire rx_bit_fetch_ready,
   input wire rx_bit_fetch_valid,
   input wire rx_bit_fetch_data,
   input wire rx_bit_undefined,
   input wire wait_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   a_ready_needs_tx:
      assert property (tx_bit_transfer_ready |->
         $past(tx_active && tx_bit_transfer_valid)) else $error("tx ready idle");
   a_ready_single_pulse:
      assert property (tx_bit_transfer_ready |=> !tx_bit_transfer_ready)
      else $error("tx ready too long");
   a_coll_only_tx:
      assert property (collision_flag |-> $past(tx_active))
      else $error("collision outside transmission");
   // Writes may change the collide control, so only quiet stretches count
   a_coll_held:
      assert property ((!s_axi_awvalid)[*6] ##0 (collision_flag && tx_active)
         |=> collision_flag) else $error("collision dropped early");
   a_rx_single_pulse:
      assert property (rx_bit_fetch_valid |=> !rx_bit_fetch_valid)
      else $error("rx valid too long");
   a_rx_on_request:
      assert property (rx_bit_fetch_valid |-> $past(rx_bit_fetch_ready))
      else $error("rx bit without request");
   a_rx_needs_carrier:
      assert property (rx_bit_fetch_valid && !rx_bit_undefined |->
         $past(carrier_present)) else $error("rx bit without carrier");
   a_junk_bit_zero:
      assert property (rx_bit_undefined |-> rx_bit_fetch_valid &&
         !rx_bit_fetch_data) else $error("junk bit malformed");
   a_wait_single_pulse:
      assert property (wait_done |=> !wait_done)
      else $error("wait done too long");
endmodule

bind phy_link_host phy_link_host_chk chk_u (.sys_clk, .rst_n,
   .s_axi_awvalid, .tx_active, .tx_bit_transfer_valid,
   .tx_bit_transfer_ready, .collision_flag, .carrier_present,
   .rx_bit_fetch_ready, .rx_bit_fetch_valid, .rx_bit_fetch_data,
   .rx_bit_undefined, .wait_done);

// ---- tb/link_side_model.sv ----
// Data link side model: frame sender, bit collector and wait client
module link_side_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   output logic tx_active = 1'b0,
   output logic tx_bit_transfer_valid = 1'b0,
   output logic tx_bit_transfer_data = 1'b0,
   input wire logic tx_bit_transfer_ready,
   input wire logic collision_flag,
   input wire logic carrier_present,
   output logic rx_bit_fetch_ready = 1'b0,
   input wire logic rx_bit_fetch_valid,
   input wire logic rx_bit_fetch_data,
   input wire logic rx_bit_undefined,
   output logic wait_req = 1'b0,
   output logic [15:0] wait_bits = 16'h0000,
   input wire logic wait_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] rx_bits;
   logic saw_coll;
   int rx_count, undef_count, tx_cyc, coll_at, first_lat;
   ////////////////////////////////////////////////////////////
   // Collision is watched beside the sender, since it may rise and stay
   // inside the long first bit, before any ready comes
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         rx_bit_fetch_ready <= 1'b0;
         rx_bits <= 16'h0000;
         rx_count <= 0;
         undef_count <= 0;
         saw_coll <= 1'b0;
         tx_cyc <= 0;
         coll_at <= 0;
      end
      else
      begin
         rx_bit_fetch_ready <= carrier_present;
         if (rx_bit_fetch_valid && rx_bit_fetch_ready)
         begin
            if (rx_bit_undefined)
               undef_count <= undef_count + 1;
            else
            begin
               rx_bits <= {rx_bit_fetch_data, rx_bits[15:1]};
               rx_count <= rx_count + 1;
            end
         end
         tx_cyc <= tx_active ? tx_cyc + 1 : 0;
         if (tx_active && collision_flag && !saw_coll)
         begin
            saw_coll <= 1'b1;
            coll_at <= tx_cyc;
         end
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic send_frame(input logic [15:0] bits, input int n);
      int i;
      int g;
      i = 0;
      g = 0;
      first_lat = 0;
      while (carrier_present)
         @(posedge sys_clk);
      tx_active <= 1'b1;
      tx_bit_transfer_valid <= 1'b1;
      tx_bit_transfer_data <= bits[0];
      while (i < n && g < 4000)
      begin
         @(posedge sys_clk);
         g++;
         if (tx_bit_transfer_ready)
         begin
            if (i == 0) first_lat = g;
            i++;
            // Past the last bit the line shows the inverse, never stale data
            tx_bit_transfer_data <= (i < n) ? bits[i % 16] :
               ~bits[(n - 1) % 16];
         end
      end
      tx_bit_transfer_valid <= 1'b0;
      tx_active <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic wait_time(input logic [15:0] n, output int cyc);
      wait_bits <= n;
      wait_req <= 1'b1;
      @(posedge sys_clk);
      wait_req <= 1'b0;
      cyc = 0;
      while (!wait_done && cyc < 4000)
      begin
         @(posedge sys_clk);
         cyc++;
      end
   endtask
endmodule

// ---- tb/phy_link_host_tb.sv ----
// Self-checking bench for the bit link controller
`include "phy_side_consts.vh"

module phy_link_host_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, rst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, tx_active, tx_bit_transfer_valid, wait_done;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic tx_bit_transfer_data, tx_bit_transfer_ready, collision_flag;
   logic carrier_present, rx_bit_fetch_ready, rx_bit_fetch_valid;
   logic rx_bit_fetch_data, rx_bit_undefined, wait_req;
   logic [15:0] wait_bits;
   int errors = 0, cmp_count = 0, c;

   phy_link_host dut_u (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_active,
      .tx_bit_transfer_valid, .tx_bit_transfer_data, .tx_bit_transfer_ready,
      .collision_flag, .carrier_present, .rx_bit_fetch_ready,
      .rx_bit_fetch_valid, .rx_bit_fetch_data, .rx_bit_undefined,
      .wait_req, .wait_bits, .wait_done);
   link_side_model link_u (.sys_clk, .rst_n, .tx_active,
      .tx_bit_transfer_valid, .tx_bit_transfer_data, .tx_bit_transfer_ready,
      .collision_flag, .carrier_present, .rx_bit_fetch_ready,
      .rx_bit_fetch_valid, .rx_bit_fetch_data, .rx_bit_undefined,
      .wait_req, .wait_bits, .wait_done);

   always #25 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("Compares %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Ready lines stay high, so a response is never missed
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
   endtask

   task automatic axi_read(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic test_registers();
      axi_read(`REG_CTRL);
      check("ctrl reset", rd, 32'h0);
      axi_read(`REG_STRETCH);
      check("stretch reset", rd, `STRETCH_RESET);
      axi_read(`REG_COLL_DELAY);
      check("delay reset", rd, `COLL_DELAY_RESET);
      axi_read(8'h1c);
      check("unmapped read", {rd[29:0], resp}, {30'h0, `RESP_SLVERR});
      axi_write(8'h20, 32'h1);
      check("unmapped write", resp, `RESP_SLVERR);
      $display("Test registers done");
   endtask

   task automatic test_tx_frames();
      logic [15:0] pat [2] = '{16'ha501, 16'h1ffe};
      logic [31:0] len [2] = '{32'h10, 32'h0d};
      logic [7:0] oct [2] = '{8'ha5, 8'hfe};
      logic [31:0] st [2] = '{32'h260, 32'h160};
      axi_write(`REG_STRETCH, 32'h4);
      check("write okay", resp, `RESP_OKAY);
      axi_read(`REG_STRETCH);
      check("stretch write", rd, 32'h4);
      for (int i = 0; i < 2; i++)
      begin
         link_u.send_frame(pat[i], len[i]);
         check("first bit wait", link_u.first_lat >= 7, 1'b1);
         axi_read(`REG_TX_COUNT);
         check("bit count", rd, len[i]);
         axi_read(`REG_TX_DATA);
         check("last octet", rd[7:0], oct[i]);
         axi_read(`REG_STATUS);
         check("frame status", rd & 32'h3e0, st[i]);
      end
      check("no collision", link_u.saw_coll, 1'b0);
      $display("Test transmit frames done");
   endtask

   // Delay above the round trip must clamp, so the hit lands in the stretch
   task automatic test_collision();
      axi_write(`REG_STRETCH, 32'h1cc);
      axi_write(`REG_COLL_DELAY, 32'h3e8);
      axi_write(`REG_CTRL, 32'h1);
      link_u.send_frame(16'h00ff, 8);
      c = link_u.coll_at;
      check("collision seen", link_u.saw_coll, 1'b1);
      check("hit in first bit", c < link_u.first_lat, 1'b1);
      check("collision time", c >= 896 && c <= 906, 1'b1);
      axi_write(`REG_CTRL, 32'h0);
      axi_write(`REG_STRETCH, 32'h4);
      $display("Test collision done");
   endtask

   task automatic test_receive();
      axi_write(`REG_CTRL, 32'h2);
      for (int k = 0; k < 2; k++)
      begin
         axi_write(`REG_RX_DATA, k ? 32'h3c : 32'ha5);
         c = 0;
         while (link_u.rx_count < 8 * (k + 1) && c < 400)
         begin
            @(posedge sys_clk);
            c++;
         end
      end
      check("received bits", link_u.rx_bits, 16'h3ca5);
      axi_read(`REG_RX_DATA);
      check("feed empty", rd[0], 1'b0);
      axi_write(`REG_CTRL, 32'h0);
      repeat (6) @(posedge sys_clk);
      check("junk bits", link_u.undef_count, 1);
      check("frame bits", link_u.rx_count, 16);
      $display("Test receive done");
   endtask

   task automatic test_wait();
      link_u.wait_time(16'h0000, c);
      check("zero wait", c, 1);
      link_u.wait_time(16'h0005, c);
      check("five bit wait", c >= 9 && c <= 12, 1'b1);
      $display("Test wait done");
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      summarize();
   end

   initial
   begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      test_registers();
      test_tx_frames();
      test_collision();
      test_receive();
      test_wait();
      summarize();
   end
endmodule
